// ==== dv/rlas_asserts.sv ====
// Port checks for the receive alignment block
`timescale 1ns/1ps
`include "rlas_defs.svh"
module rlas_asserts
  import rlas_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic rxReceivePermit,
  input wire logic rxRealignRequest,
  input wire logic [`RLAS_LANES-1:0] laneHdrValid,
  input wire logic decWordValid,
  input wire logic decSop,
  input wire logic decEop,
  input wire rlas_cnt_t statFramingErr,
  input wire logic [`RLAS_LANES-1:0] statFramingErrValid,
  input wire logic busEna,
  input wire logic busSop,
  input wire logic busEop,
  input wire logic rxAligned
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence reqHeld; rxRealignRequest [*4]; endsequence
  sequence permitOff; !rxReceivePermit [*3]; endsequence
  realign_clears_a: assert property (reqHeld |=> !rxAligned)
    else $error("aligned flag kept through realign");
  no_spurious_a: assert property ($fell(rxAligned) |-> $past(rxRealignRequest, 2)
    || $past(rxRealignRequest, 3) || $past(rxRealignRequest, 4)) else $error("alignment lost");
  sop_dropped_a: assert property (permitOff ##0 (decWordValid && decSop) |=> !busSop)
    else $error("new packet taken while disabled");
  bus_echo_a: assert property (busEna |-> $past(decWordValid) && busSop == $past(decSop)
    && busEop == $past(decEop)) else $error("bus word mismatch");
  idle_quiet_a: assert property (!rxAligned && $past(!rxAligned)
    |-> !busEna && !(|statFramingErrValid)) else $error("output while not running");
  err_value_a: assert property (statFramingErrValid[0]
    |-> $past(laneHdrValid[0]) && statFramingErr[0] <= 4'h8) else $error("bad error count");
  valid_pulse_a: assert property (statFramingErrValid[0] |=> !statFramingErrValid[0])
    else $error("valid too long");
  err_hold_a: assert property ($changed(statFramingErr[0]) && rxAligned
    |-> statFramingErrValid[0]) else $error("count changed without valid");
endmodule : rlas_asserts
bind rlas_rx_align rlas_asserts i_rlas_asserts (.*);

// ==== dv/rlas_partner.sv ====
// User-side model that accumulates per-lane sync header errors
`timescale 1ns/1ps
`include "rlas_defs.svh"
module rlas_partner
  import rlas_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire rlas_cnt_t statFramingErr,
  input wire logic [`RLAS_LANES-1:0] statFramingErrValid,
  output logic [`RLAS_LANES-1:0][7:0] errSum_q
);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) errSum_q <= '0;
    else for (int i = 0; i < `RLAS_LANES; i++) begin
      if (statFramingErrValid[i]) errSum_q[i] <= errSum_q[i] + 8'(statFramingErr[i]);
    end
  end
endmodule : rlas_partner

// ==== dv/tb_top.sv ====
// Self-checking bench for the receive alignment block
`timescale 1ns/1ps
`include "rlas_defs.svh"
module tb_top;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic rxReceivePermit = 1'b1;
  logic rxRealignRequest = 1'b0;
  logic [`RLAS_LANES-1:0] laneHdrValid = '0;
  logic [`RLAS_LANES-1:0][1:0] laneSyncHdr = '0;
  logic decWordValid = 1'b0;
  logic decSop = 1'b0;
  logic decEop = 1'b0;
  logic [`RLAS_LANES-1:0][`RLAS_CNT_W-1:0] statFramingErr;
  logic [`RLAS_LANES-1:0] statFramingErrValid;
  logic busEna, busSop, busEop, rxAligned;
  logic [`RLAS_LANES-1:0][7:0] errSum_q;
  logic [7:0] nWords = 8'h00;
  int err_total = 0;
  int n_checks = 0;
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) if (busEna === 1'b1) nWords <= nWords + 8'h01;
  rlas_rx_align i_rlas_rx_align (
    .core_clk(core_clk), .rst_n(rst_n),
    .rxReceivePermit(rxReceivePermit), .rxRealignRequest(rxRealignRequest),
    .laneHdrValid(laneHdrValid), .laneSyncHdr(laneSyncHdr),
    .decWordValid(decWordValid), .decSop(decSop), .decEop(decEop),
    .statFramingErr(statFramingErr), .statFramingErrValid(statFramingErrValid),
    .busEna(busEna), .busSop(busSop), .busEop(busEop), .rxAligned(rxAligned)
  );
  rlas_partner i_rlas_partner (
    .core_clk(core_clk), .rst_n(rst_n),
    .statFramingErr(statFramingErr), .statFramingErrValid(statFramingErrValid),
    .errSum_q(errSum_q)
  );
  task tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Lane 0 alternates both bad codes so each is seen
  task hdrs(input int n, input int bad);
    for (int i = 0; i < n; i++) begin
      laneHdrValid = '1;
      laneSyncHdr[0] = (i < bad) ? (i[0] ? 2'h3 : 2'h0) : `RLAS_SYNC_GOOD_A;
      for (int l = 1; l < `RLAS_LANES; l++) laneSyncHdr[l] = l[0] ? `RLAS_SYNC_GOOD_B : 2'h1;
      tick(1);
    end
    laneHdrValid = '0;
  endtask : hdrs
  task frame(input int n, input int drop);
    for (int i = 0; i < n; i++) begin
      decWordValid = 1'b1;
      decSop = (i == 0);
      decEop = (i == n - 1);
      if (i == drop) rxReceivePermit = 1'b0;
      tick(1);
    end
    decWordValid = 1'b0;
  endtask : frame
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  initial begin
    tick(8);
    rst_n = 1'b1;
    // The first edge after release only leaves reset, so headers wait one cycle
    tick(1);
    hdrs(16, 0);
    tick(2);
    chk("aligned", 8'h01, {7'h0, rxAligned});
    hdrs(8, 3);
    tick(1);
    chk("lane0 sum", 8'h03, errSum_q[0]);
    chk("lane19 sum", 8'h00, errSum_q[19]);
    frame(3, 1);
    tick(1);
    frame(2, 9);
    tick(2);
    chk("words", 8'h03, nWords);
    hdrs(8, 8);
    tick(2);
    chk("halt sum", 8'h03, errSum_q[0]);
    rxReceivePermit = 1'b1;
    tick(2);
    frame(1, 9);
    tick(2);
    chk("words", 8'h04, nWords);
    chk("still aligned", 8'h01, {7'h0, rxAligned});
    rxRealignRequest = 1'b1;
    tick(4);
    rxRealignRequest = 1'b0;
    tick(4);
    chk("realign drop", 8'h00, {7'h0, rxAligned});
    hdrs(16, 0);
    tick(2);
    chk("aligned again", 8'h01, {7'h0, rxAligned});
    // Shortest request after stretching: one clock period
    rxRealignRequest = 1'b1;
    tick(1);
    rxRealignRequest = 1'b0;
    tick(4);
    chk("short realign", 8'h00, {7'h0, rxAligned});
    tally_and_finish();
  end
endmodule : tb_top

// ==== hw/rlas_defs.svh ====
// Constants for the receive lane alignment and statistics block
`ifndef RLAS_DEFS_SVH
`define RLAS_DEFS_SVH
`define RLAS_LANES 20
`define RLAS_CNT_W 4
`define RLAS_LOCK_GOOD 5'h10
`define RLAS_LOCK_W 5
`define RLAS_REPORT_HDRS 3'h7
`define RLAS_HDR_W 3
`define RLAS_REQ_MIN_NS 5
`define RLAS_CLK_PERIOD_NS 25
`define RLAS_SYNC_GOOD_A 2'h1
`define RLAS_SYNC_GOOD_B 2'h2
`endif

// ==== hw/rlas_pkg.sv ====
// Types for the receive lane alignment and statistics block
`include "rlas_defs.svh"
package rlas_pkg;
  typedef enum logic [2:0] {ST_RESET, ST_ALIGN, ST_RUN, ST_DRAIN, ST_HALT} rlas_state_e;
  typedef logic [`RLAS_LANES-1:0][`RLAS_CNT_W-1:0] rlas_cnt_t;
  typedef logic [`RLAS_LANES-1:0][`RLAS_LOCK_W-1:0] rlas_lock_t;
  typedef logic [`RLAS_LANES-1:0][`RLAS_HDR_W-1:0] rlas_hdr_t;
endpackage : rlas_pkg

// ==== hw/rlas_rx_align.sv ====
// Receive path control, lane alignment and per-lane sync header error statistics
// Summary of operation
// - Permit low: finish packet in progress, then halt decoding of lane data.
// - While disabled, no statistics are reported and the packet bus stays idle.
// - Realign request high: reset receive path, then resync and realign all lanes.
// - Realign request low: normal reception continues with no forced reset.
// - Each lane outputs a four-bit count of received sync header errors.
// - Each of lanes 0..19 has a valid; count means something only when valid.
// - Counts may update in any cycle, regardless of packet boundaries.
`timescale 1ns/1ps
`include "rlas_defs.svh"
module rlas_rx_align
  import rlas_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic rxReceivePermit,
  input wire logic rxRealignRequest,
  input wire logic [`RLAS_LANES-1:0] laneHdrValid,
  input wire logic [`RLAS_LANES-1:0][1:0] laneSyncHdr,
  input wire logic decWordValid,
  input wire logic decSop,
  input wire logic decEop,
  output logic [`RLAS_LANES-1:0][`RLAS_CNT_W-1:0] statFramingErr,
  output logic [`RLAS_LANES-1:0] statFramingErrValid,
  output logic busEna,
  output logic busSop,
  output logic busEop,
  output logic rxAligned
);

  typedef struct packed {
    rlas_state_e state;
    logic inPkt;
    rlas_lock_t lockCnt;
    rlas_cnt_t errAcc;
    rlas_hdr_t hdrCnt;
    rlas_cnt_t errOut;
    logic [`RLAS_LANES-1:0] errValid;
    logic busEna;
    logic busSop;
    logic busEop;
    logic aligned;
  } rlas_regs_s;

  rlas_regs_s r_q;
  rlas_regs_s r_d;
  logic realignSync;

  // A good sync header is 01 or 10; 00 and 11 count as framing errors
  function automatic logic hdrBad(input logic [1:0] hdr);
    hdrBad = (hdr != `RLAS_SYNC_GOOD_A) && (hdr != `RLAS_SYNC_GOOD_B);
  endfunction : hdrBad

  // Per-lane header decode, shared by the lock and the statistics logic
  logic [`RLAS_LANES-1:0] hdrIsBad;
  logic [`RLAS_LANES-1:0] hdrIsGood;
  logic [`RLAS_LANES-1:0] laneLocked;
  logic [`RLAS_LANES-1:0] windowLast;

  for (genvar g = 0; g < `RLAS_LANES; g++) begin : g_lane
    assign hdrIsBad[g] = laneHdrValid[g] && hdrBad(laneSyncHdr[g]);
    assign hdrIsGood[g] = laneHdrValid[g] && !hdrBad(laneSyncHdr[g]);
    assign laneLocked[g] = (r_q.lockCnt[g] == `RLAS_LOCK_GOOD);
    // Eighth header of the window: the count is released on this one
    assign windowLast[g] = (r_q.hdrCnt[g] == `RLAS_REPORT_HDRS);
  end

  // The request may be as short as 5 ns, shorter than a clock period; the
  // far end is expected to stretch it to a full cycle so both flops see it
  rlas_sync u_realign_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .asyncIn(rxRealignRequest),
    .syncOut(realignSync)
  );

  always_comb begin
    logic accept;
    logic nextInPkt;
    logic [`RLAS_CNT_W-1:0] sum;
    accept = 1'b0;
    nextInPkt = 1'b0;
    sum = '0;
    r_d = r_q;
    // Strobes live one cycle only
    r_d.errValid = '0;
    r_d.busEna = 1'b0;
    r_d.busSop = 1'b0;
    r_d.busEop = 1'b0;
    if (realignSync) begin
      // Held in reset for as long as the request stays high
      r_d.state = ST_RESET;
      r_d.inPkt = 1'b0;
      r_d.lockCnt = '0;
      r_d.errAcc = '0;
      r_d.hdrCnt = '0;
      r_d.aligned = 1'b0;
    end else begin
      case (r_q.state)
        ST_RESET: begin
          r_d.state = ST_ALIGN;
        end
        ST_ALIGN: begin
          // A bad header restarts that lane's run of good ones
          for (int i = 0; i < `RLAS_LANES; i++) begin
            if (hdrIsBad[i]) begin
              r_d.lockCnt[i] = '0;
            end else if (hdrIsGood[i] && !laneLocked[i]) begin
              r_d.lockCnt[i] = r_q.lockCnt[i] + `RLAS_LOCK_W'(1);
            end
          end
          if (&laneLocked) begin
            r_d.aligned = 1'b1;
            r_d.state = rxReceivePermit ? ST_RUN : ST_HALT;
          end
        end
        ST_RUN, ST_DRAIN: begin
          // Statistics per lane, released when a window closes unless the block halts in that cycle
          for (int i = 0; i < `RLAS_LANES; i++) begin
            if (laneHdrValid[i]) begin
              sum = r_q.errAcc[i] + {3'h0, hdrIsBad[i]};
              if (windowLast[i]) begin
                r_d.errOut[i] = sum;
                r_d.errValid[i] = 1'b1;
                r_d.errAcc[i] = '0;
                r_d.hdrCnt[i] = '0;
              end else begin
                r_d.errAcc[i] = sum;
                r_d.hdrCnt[i] = r_q.hdrCnt[i] + `RLAS_HDR_W'(1);
              end
            end
          end
          // A new packet may only start while running; draining only finishes one
          accept = decWordValid && (r_q.inPkt || (decSop && r_q.state == ST_RUN));
          nextInPkt = r_q.inPkt;
          if (accept) begin
            r_d.busEna = 1'b1;
            r_d.busSop = decSop && !r_q.inPkt;
            r_d.busEop = decEop;
            nextInPkt = !decEop;
          end
          r_d.inPkt = nextInPkt;
          if (!rxReceivePermit || r_q.state == ST_DRAIN) begin
            r_d.state = nextInPkt ? ST_DRAIN : ST_HALT;
          end
          if (r_d.state == ST_HALT) begin
            // Partial windows are dropped so nothing leaks out while disabled
            r_d.errAcc = '0;
            r_d.hdrCnt = '0;
            // A window closing on the disabling edge is withheld as well
            r_d.errOut = r_q.errOut;
            r_d.errValid = '0;
          end
        end
        ST_HALT: begin
          // Decoding stopped: no statistics, bus idle
          if (rxReceivePermit) begin
            r_d.state = ST_RUN;
          end
        end
        default: begin
          r_d.state = ST_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      r_q <= '{state: ST_RESET, default: '0};
    end else begin
      r_q <= r_d;
    end
  end

  assign statFramingErr = r_q.errOut;
  assign statFramingErrValid = r_q.errValid;
  assign busEna = r_q.busEna;
  assign busSop = r_q.busSop;
  assign busEop = r_q.busEop;
  assign rxAligned = r_q.aligned;

endmodule : rlas_rx_align

// ==== hw/rlas_sync.sv ====
// Two flip-flop level synchroniser
`timescale 1ns/1ps
module rlas_sync (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic asyncIn,
  output logic syncOut
);
  typedef struct packed {
    logic meta;
    logic stable;
  } rlas_sync_s;

  rlas_sync_s s_q;
  rlas_sync_s s_d;

  // Only the second stage is read, so a metastable first stage never reaches logic
  always_comb begin
    s_d.meta = asyncIn;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign syncOut = s_q.stable;
endmodule : rlas_sync
